//--- rtl/acsd_decoder.sv
`timescale 1ns/10ps
`include "acsd_cfg.svh"
module acsd_decoder
  import acsd_pkg::*;
#(
  parameter logic [31:0]  CAPACITY     = 32'h0001_0000,
  parameter logic [159:0] SERIAL_STR   = "0000000000000001",
  parameter logic [319:0] MODEL_STR    = "SOLID STATE DISK",
  parameter logic [1:0]   MWDMA_MODE   = 2'd2,
  parameter logic [15:0]  CTRL_REV     = 16'h0100,
  parameter logic         SMART_NV_DEF = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        soft_rst,
  input  wire logic [2:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic        data_rd,
  output logic      [15:0] data_word,
  output logic             data_valid,
  input  wire logic        nv_smart_en,
  input  wire logic        nv_valid,
  output logic             nv_write,
  output logic             nv_smart_val,
  input  wire logic        defect_pred,
  output logic             smart_active,
  output logic      [3:0]  lba_head,
  output logic             drive_sel
);

  acsd_state_t    state;
  acsd_src_t      src;
  acsd_taskfile_t tf;
  acsd_status_t   st;
  logic [8:0]     word_idx;
  logic           smart_en;
  logic [7:0]     cyl_lo_out;
  logic [7:0]     cyl_hi_out;

  function automatic logic [15:0] str_word(input logic [319:0] s, input int n, input int len);
    logic [15:0] w;
    w = 16'h0000;
    if (n < len) begin
      w = s[(len - 1 - n) * 16 +: 16];
    end
    return w;
  endfunction

  // A model text shorter than its field is moved to the top, so it reads left-justified.
  function automatic logic [319:0] left_just(input logic [319:0] s);
    logic [319:0] r;
    r = s;
    for (int k = 0; k < 40; k++) begin
      if (r[319:312] == 8'h00) begin
        r = {r[311:0], 8'h00};
      end
    end
    return r;
  endfunction

  localparam logic [319:0] MODEL_LJ = left_just(MODEL_STR);

  function automatic logic op_known(input logic [7:0] op);
    logic k;
    case (op)
      8'he5, 8'h98, 8'h06, 8'h92, 8'h90, 8'he7, 8'hea, 8'hec, 8'he3, 8'h97,
      8'he1, 8'h95, 8'hde, 8'hdf, 8'h00, 8'he4, 8'hc8, 8'hc9, 8'h25, 8'h60,
      8'h2f, 8'hc4, 8'h29, 8'hf8, 8'h27, 8'h20, 8'h21, 8'h24, 8'h40, 8'h41,
      8'h42, 8'hf6, 8'hf3, 8'hf4, 8'hf5, 8'hf1, 8'hf2, 8'hef, 8'hf9, 8'h37,
      8'hc6, 8'he6, 8'h99, 8'hb0, 8'he2, 8'h96, 8'he0, 8'h94, 8'he8, 8'hca,
      8'hcb, 8'h35, 8'h61, 8'hc5, 8'h39, 8'h30, 8'h31, 8'h34, 8'h3c, 8'h50: k = 1'b1;
      default: k = (op[7:4] == 4'h1) || (op[7:4] == 4'h7);
    endcase
    return k;
  endfunction

  // drive/head marked Y: head bits are used.
  function automatic logic uses_head(input logic [7:0] op);
    logic h;
    case (op)
      8'h50, 8'hc8, 8'hc9, 8'h60, 8'hc4, 8'h20, 8'h21, 8'h40, 8'h41, 8'hf9,
      8'hca, 8'hcb, 8'hc5, 8'h30, 8'h31, 8'h3c: h = 1'b1;
      default: h = (op[7:4] == 4'h7);
    endcase
    return h;
  endfunction

  // Identify sector content, checksum excluded.
  function automatic logic [15:0] ident_word(input logic [7:0] i);
    logic [15:0] w;
    w = 16'h0000;
    if (i == 8'd5) begin
      w = `ACSD_W_BYTES_SEC;
    end else if (i >= 8'd10 && i <= 8'd19) begin
      w = str_word({160'h0, SERIAL_STR}, int'(i) - 10, 10);
    end else if (i >= 8'd27 && i <= 8'd46) begin
      w = str_word(MODEL_LJ, int'(i) - 27, 20);
    end else if (i == 8'd47) begin
      w = `ACSD_W_MULTI;
    end else if (i == 8'd57) begin
      w = CAPACITY[15:0];
    end else if (i == 8'd58) begin
      w = CAPACITY[31:16];
    end else if (i == 8'd63) begin
      w = {8'(8'h01 << MWDMA_MODE), `ACSD_W_MWDMA_SUP};
    end else if (i == 8'd75) begin
      w = `ACSD_W_QDEPTH;
    end else if (i == 8'd159) begin
      // Controller revision value is arbitrary.
      w = CTRL_REV;
    end else if (i == 8'd255) begin
      w = {8'h00, `ACSD_W_INTEGRITY};
    end
    return w;
  endfunction

  function automatic logic [7:0] ident_sum();
    logic [7:0] s;
    logic [15:0] w;
    s = 8'h00;
    for (int j = 0; j < 256; j++) begin
      w = ident_word(8'(j));
      s = 8'(s + w[15:8] + w[7:0]);
    end
    return s;
  endfunction

  // checksum byte making the sector sum zero.
  localparam logic [7:0] IDENT_CSUM = 8'(8'h00 - ident_sum());

  wire        cmd_wr     = wr && (addr == `ACSD_ADDR_CMD) && (state == ACSD_IDLE);
  wire        is_smart   = (wdata == `ACSD_OP_SMART);
  wire        is_ident   = (wdata == `ACSD_OP_IDENTIFY);
  wire        is_known   = op_known(wdata);
  // SMART function chosen from the feature parameter only.
  wire [7:0]  sub        = tf.feature;
  wire        sub_ok     = (sub == `ACSD_SM_READ_DATA) || (sub == `ACSD_SM_THRESH) ||
                           (sub == `ACSD_SM_AUTOSAVE) || (sub == `ACSD_SM_READ_LOG) ||
                           (sub == `ACSD_SM_WRITE_LOG) || (sub == `ACSD_SM_ENABLE) ||
                           (sub == `ACSD_SM_DISABLE) || (sub == `ACSD_SM_STATUS) ||
                           (sub == `ACSD_SM_REMAP) || (sub == `ACSD_SM_WEAR);
  // autosave takes only 00h or F1h.
  wire        as_ok      = (tf.count == `ACSD_AS_ON) || (tf.count == `ACSD_AS_OFF);
  // disabled SMART aborts all but enable.
  wire        smart_abort_flag = !sub_ok || (!smart_en && sub != `ACSD_SM_ENABLE) ||
                           (sub == `ACSD_SM_AUTOSAVE && !as_ok);
  wire        smart_xfer = (sub == `ACSD_SM_READ_DATA);
  // unknown opcode aborts with no data phase.
  wire        abort_now  = !is_known || (is_smart && smart_abort_flag);
  wire        start_data = !abort_now && (is_ident || (is_smart && smart_xfer));
  // The word after a taken one is fetched at once, so a held take strobe never repeats a word.
  wire        word_take  = data_rd && data_valid;
  wire [8:0]  fetch_idx  = word_take ? 9'(word_idx + 9'd1) : word_idx;
  wire [15:0] smart_word = (fetch_idx == 9'd0) ? `ACSD_SMART_REV : 16'h0000;
  wire [15:0] id_word    = (fetch_idx == 9'd255) ? {IDENT_CSUM, `ACSD_W_INTEGRITY}
                                                 : ident_word(fetch_idx[7:0]);
  wire [15:0] next_word  = (src == ACSD_SRC_IDENT) ? id_word :
                           (src == ACSD_SRC_SMART) ? smart_word : 16'h0000;
  wire [7:0]  status_rd  = {st.busy, !st.busy, 1'b0, !st.busy, st.drq, 2'b00, st.err};
  wire [7:0]  next_rdata = (addr == `ACSD_ADDR_STATUS) ? status_rd :
                           (addr == `ACSD_ADDR_CMD)    ? st.error :
                           (addr == `ACSD_ADDR_FEAT)   ? tf.feature :
                           (addr == `ACSD_ADDR_COUNT)  ? tf.count :
                           (addr == `ACSD_ADDR_SECT)   ? tf.sector :
                           (addr == `ACSD_ADDR_CYLLO)  ? cyl_lo_out :
                           (addr == `ACSD_ADDR_CYLHI)  ? cyl_hi_out :
                                                         tf.drive_head;
  wire        rst_any    = rst || soft_rst;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tf <= '0;
    end else if (wr && state == ACSD_IDLE) begin
      if (addr == `ACSD_ADDR_FEAT) tf.feature <= wdata;
      if (addr == `ACSD_ADDR_COUNT) tf.count <= wdata;
      if (addr == `ACSD_ADDR_SECT) tf.sector <= wdata;
      if (addr == `ACSD_ADDR_CYLLO) tf.cyl_lo <= wdata;
      if (addr == `ACSD_ADDR_CYLHI) tf.cyl_hi <= wdata;
      if (addr == `ACSD_ADDR_DRVHD) tf.drive_head <= wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  // enable state loaded from and saved to non-volatile storage.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smart_en     <= SMART_NV_DEF;
      nv_write     <= 1'b0;
      nv_smart_val <= SMART_NV_DEF;
    end else begin
      nv_write <= 1'b0;
      if (nv_valid) begin
        smart_en <= nv_smart_en;
      end else if (cmd_wr && is_smart && !smart_abort_flag) begin
        // repeated enable has no side effect.
        if (sub == `ACSD_SM_ENABLE && !smart_en) begin
          smart_en     <= 1'b1;
          nv_write     <= 1'b1;
          nv_smart_val <= 1'b1;
        end else if (sub == `ACSD_SM_DISABLE) begin
          smart_en     <= 1'b0;
          nv_write     <= smart_en;
          nv_smart_val <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smart_active <= 1'b0;
    end else begin
      smart_active <= smart_en;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lba_head  <= 4'h0;
      drive_sel <= 1'b0;
    end else if (cmd_wr && is_known) begin
      lba_head  <= uses_head(wdata) ? tf.drive_head[3:0] : 4'h0;
      drive_sel <= tf.drive_head[4];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state      <= ACSD_IDLE;
      src        <= ACSD_SRC_ZERO;
      st         <= '0;
      word_idx   <= 9'd0;
      data_word  <= 16'h0000;
      data_valid <= 1'b0;
      cyl_lo_out <= 8'h00;
      cyl_hi_out <= 8'h00;
    end else if (soft_rst) begin
      state      <= ACSD_IDLE;
      st         <= '0;
      data_valid <= 1'b0;
    end else begin
      case (state)
        ACSD_IDLE: begin
          // Cylinder reads echo host writes until a status command loads its signature.
          if (wr && addr == `ACSD_ADDR_CYLLO) cyl_lo_out <= wdata;
          if (wr && addr == `ACSD_ADDR_CYLHI) cyl_hi_out <= wdata;
          if (cmd_wr) begin
            st.busy  <= 1'b1;
            st.err   <= abort_now;
            // abort flag in error bit 2.
            st.error <= abort_now ? 8'(1 << `ACSD_ERR_ABORT_BIT) : 8'h00;
            word_idx <= 9'd0;
            src      <= is_ident ? ACSD_SRC_IDENT : ACSD_SRC_SMART;
            state    <= start_data ? ACSD_DATA : ACSD_DONE;
            if (is_smart && !smart_abort_flag && sub == `ACSD_SM_STATUS) begin
              cyl_lo_out <= defect_pred ? `ACSD_BAD_LO : `ACSD_SIG_LO;
              cyl_hi_out <= defect_pred ? `ACSD_BAD_HI : `ACSD_SIG_HI;
            end
          end
        end
        ACSD_DATA: begin
          // PIO read style: DRQ set, one word per host read.
          st.busy    <= 1'b0;
          st.drq     <= 1'b1;
          data_valid <= 1'b1;
          data_word  <= next_word;
          if (data_rd && data_valid) begin
            if (word_idx == `ACSD_SEC_WORDS - 9'd1) begin
              state      <= ACSD_DONE;
              data_valid <= 1'b0;
              st.drq     <= 1'b0;
            end else begin
              word_idx <= 9'(word_idx + 9'd1);
            end
          end
        end
        default: begin
          st.busy <= 1'b0;
          st.drq  <= 1'b0;
          state   <= ACSD_IDLE;
        end
      endcase
    end
  end

  chk_abort_flag: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && !is_known) |=> (st.error[2] && st.err && state == ACSD_DONE))
    else $error("unknown opcode not aborted");
  chk_no_data_abort: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && !is_known) |=> ##1 !data_valid)
    else $error("aborted command entered data phase");
  chk_smart_gate: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && is_smart && !smart_en && sub != `ACSD_SM_ENABLE) |=> st.error[2])
    else $error("SMART accepted while disabled");
  chk_enable_quiet: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && is_smart && smart_en && sub == `ACSD_SM_ENABLE && !nv_valid)
    |=> (!nv_write && smart_en))
    else $error("repeated enable had side effect");
  chk_disable_stop: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && is_smart && smart_en && sub == `ACSD_SM_DISABLE && !nv_valid)
    |=> ##1 !smart_active)
    else $error("monitoring not stopped");
  chk_status_sig: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && is_smart && smart_en && sub == `ACSD_SM_STATUS && defect_pred)
    |=> (cyl_lo_out == `ACSD_BAD_LO && cyl_hi_out == `ACSD_BAD_HI))
    else $error("defect signature wrong");
  chk_ident_start: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && is_ident) |=> ##1 (data_valid && data_word == 16'h0000 && st.drq))
    else $error("identify data phase did not start");
  chk_head_mask: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && is_known && !uses_head(wdata)) |=> (lba_head == 4'h0))
    else $error("head bits used for drive-only command");
  chk_autosave_nop: assert property (@(posedge sys_clk) disable iff (rst_any)
    (cmd_wr && is_smart && smart_en && sub == `ACSD_SM_AUTOSAVE && as_ok)
    |=> (!st.err && state == ACSD_DONE && $stable(smart_en)))
    else $error("autosave not a plain no-op");

  cov_identify: cover property (@(posedge sys_clk) disable iff (rst_any) cmd_wr && is_ident);
  cov_smart_read: cover property (@(posedge sys_clk) disable iff (rst_any)
    cmd_wr && is_smart && sub == `ACSD_SM_READ_DATA && smart_en);
  cov_disable: cover property (@(posedge sys_clk) disable iff (rst_any)
    cmd_wr && is_smart && sub == `ACSD_SM_DISABLE);
  cov_bad_op: cover property (@(posedge sys_clk) disable iff (rst_any) cmd_wr && !is_known);

endmodule

//--- rtl/acsd_cfg.svh
// Notes on behaviour
// - Every listed opcode is accepted, including identify ECh and queued DMA 60h, 61h.
// - Only taskfile parameters valid for the opcode are used; Y uses drive and head.
// - Drive-only commands take the drive bit and ignore the head bits.
// - Identify returns its sector with the same protocol as a PIO sector read.
// - Reserved bits and words of the identify block read as zero.
// - Identify word 5 reports 512 bytes per sector as 0200h.
// - Identify word 47 reports one sector per block, 8001h.
// - Identify word 75 reports queue depth 32 as 001Fh.
// - Identify word 63 flags MWDMA 0-2; upper byte shows the selected mode.
// - Current capacity: low word in word 57, high word in word 58.
// - Serial in words 10-19 right-justified; model in 27-46 left-justified, big-endian.
// - The SMART function is chosen only by the feature parameter.
// - SMART subcodes D0 D1 D2 D5 D6 D8 D9 DA E0 E1 are decoded.
// - Enable while already enabled changes nothing.
// - The SMART enable state is kept in non-volatile storage.
// - While disabled, all SMART subcommands except enable abort.
// - Disable stops SMART timers, counters, monitoring and saving.
// - Autosave with count 00h or F1h is a no-operation.
// - Read data with feature D0h returns one 512-byte structure.
// - SMART data starts with revision 0010h, then 12-byte attribute records; here every word after the revision reads as zero.
// - Return status loads 4Fh/C2h when healthy, loads F4h/2Ch on predicted defect.
// - An aborted command sets the abort flag, bit 2 of the error register.
`ifndef ACSD_CFG_SVH
`define ACSD_CFG_SVH
`define ACSD_OP_IDENTIFY   8'hec
`define ACSD_OP_SMART      8'hb0
`define ACSD_OP_FPDMA_RD   8'h60
`define ACSD_OP_FPDMA_WR   8'h61
`define ACSD_SM_READ_DATA  8'hd0
`define ACSD_SM_THRESH     8'hd1
`define ACSD_SM_AUTOSAVE   8'hd2
`define ACSD_SM_READ_LOG   8'hd5
`define ACSD_SM_WRITE_LOG  8'hd6
`define ACSD_SM_ENABLE     8'hd8
`define ACSD_SM_DISABLE    8'hd9
`define ACSD_SM_STATUS     8'hda
`define ACSD_SM_REMAP      8'he0
`define ACSD_SM_WEAR       8'he1
`define ACSD_SIG_LO        8'h4f
`define ACSD_SIG_HI        8'hc2
`define ACSD_BAD_LO        8'hf4
`define ACSD_BAD_HI        8'h2c
`define ACSD_AS_ON         8'h00
`define ACSD_AS_OFF        8'hf1
`define ACSD_ERR_ABORT_BIT 2
`define ACSD_W_BYTES_SEC   16'h0200
`define ACSD_W_MULTI       16'h8001
`define ACSD_W_QDEPTH      16'h001f
`define ACSD_W_MWDMA_SUP   8'h07
`define ACSD_W_INTEGRITY   8'ha5
`define ACSD_SMART_REV     16'h0010
`define ACSD_SEC_WORDS     9'd256
`define ACSD_ADDR_CMD      3'h0
`define ACSD_ADDR_FEAT     3'h1
`define ACSD_ADDR_COUNT    3'h2
`define ACSD_ADDR_SECT     3'h3
`define ACSD_ADDR_CYLLO    3'h4
`define ACSD_ADDR_CYLHI    3'h5
`define ACSD_ADDR_DRVHD    3'h6
`define ACSD_ADDR_STATUS   3'h7
`endif

//--- rtl/acsd_pkg.sv
package acsd_pkg;
  typedef enum logic [1:0] {
    ACSD_IDLE = 2'b00,
    ACSD_DATA = 2'b01,
    ACSD_DONE = 2'b10
  } acsd_state_t;
  typedef enum logic [1:0] {
    ACSD_SRC_IDENT = 2'b00,
    ACSD_SRC_SMART = 2'b01,
    ACSD_SRC_ZERO  = 2'b10
  } acsd_src_t;
  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] drive_head;
  } acsd_taskfile_t;
  typedef struct packed {
    logic       busy;
    logic       drq;
    logic       err;
    logic [7:0] error;
  } acsd_status_t;
endpackage

//--- tb/acsd_host_model.sv
`timescale 1ns/10ps
module acsd_host_model (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  rdata,
  input  wire logic [15:0] data_word,
  input  wire logic        data_valid,
  output logic      [2:0]  addr,
  output logic      [7:0]  wdata,
  output logic             wr,
  output logic             rd,
  output logic             data_rd
);
  logic [15:0] buf_w [0:255];
  int          n_words;

  initial begin
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    data_rd = 1'b0;
    n_words = 0;
  end

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    d = rdata;
  endtask

  // Signature in the cylinder bytes, drive bit zero, opcode last.
  task automatic issue(input logic [7:0] op, input logic [7:0] feat, input logic [7:0] cnt,
                       input logic [3:0] head, output logic [7:0] st);
    int i;
    bus_wr(3'h1, feat);
    bus_wr(3'h2, cnt);
    bus_wr(3'h4, 8'h4f);
    bus_wr(3'h5, 8'hc2);
    bus_wr(3'h6, {4'ha, head});
    bus_wr(3'h0, op);
    st = 8'h80;
    n_words = 0;
    for (i = 0; i < 400 && st[7] && !st[3]; i++) begin
      bus_rd(3'h7, st);
    end
    // One word is taken per data_rd pulse while words are offered.
    while (data_valid === 1'b1 && n_words < 256) begin
      buf_w[n_words] = data_word;
      n_words++;
      @(posedge sys_clk);
      data_rd <= 1'b1;
      @(posedge sys_clk);
      data_rd <= 1'b0;
      @(negedge sys_clk);
    end
    st = 8'h80;
    for (i = 0; i < 400 && (st[7] || st[3]); i++) begin
      bus_rd(3'h7, st);
    end
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import acsd_pkg::*;
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] feat;
    logic [7:0] cnt;
    logic       ab;
  } acsd_row_t;

  logic        sys_clk;
  logic        rst;
  logic        soft_rst;
  logic [2:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        data_rd;
  logic [15:0] data_word;
  logic        data_valid;
  logic        nv_smart_en;
  logic        nv_valid;
  logic        nv_write;
  logic        nv_smart_val;
  logic        defect_pred;
  logic        smart_active;
  logic [3:0]  lba_head;
  logic        drive_sel;
  logic [7:0]  st;
  logic [7:0]  sum;
  logic [15:0] acc;
  int          err_total;
  int          checks;
  int          nv_writes = 0;

  acsd_row_t rows [17] = '{
    '{8'he7, 8'h00, 8'h00, 1'b0}, '{8'h60, 8'h01, 8'h08, 1'b0},
    '{8'h61, 8'h01, 8'h08, 1'b0}, '{8'h70, 8'h00, 8'h00, 1'b0},
    '{8'hff, 8'h00, 8'h00, 1'b1}, '{8'hb0, 8'hd1, 8'h01, 1'b0},
    '{8'hb0, 8'hd2, 8'h00, 1'b0}, '{8'hb0, 8'hd2, 8'hf1, 1'b0},
    '{8'hb0, 8'hd2, 8'h07, 1'b1}, '{8'hb0, 8'hd5, 8'h01, 1'b0},
    '{8'hb0, 8'hd6, 8'h01, 1'b0}, '{8'hb0, 8'hd8, 8'h00, 1'b0},
    '{8'hb0, 8'hda, 8'h00, 1'b0}, '{8'hb0, 8'he0, 8'h00, 1'b0},
    '{8'hb0, 8'he1, 8'h00, 1'b0}, '{8'hb0, 8'h33, 8'h00, 1'b1},
    '{8'h50, 8'h00, 8'h01, 1'b0}};

  acsd_decoder #(
    .CAPACITY   (32'h0012_3456),
    .SERIAL_STR ("SN0042"),
    .MODEL_STR  ("FLASH DISK"),
    .MWDMA_MODE (2'h1)
  ) DUT (.*);

  acsd_host_model host (.*);

  always #4 sys_clk = ~sys_clk;

  // The non-volatile store keeps whatever the block asks it to write.
  always @(posedge sys_clk) begin
    if (nv_write === 1'b1) begin
      nv_smart_en <= nv_smart_val;
      nv_writes   <= nv_writes + 1;
    end
  end

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] feat, input logic [7:0] cnt,
                     input logic [3:0] head);
    host.issue(op, feat, cnt, head, st);
    if (st[7] !== 1'b0 || st[3] !== 1'b0) begin
      err_total++;
      $display("[FAIL] %0t command never finished", $time);
      complete_run();
    end
  endtask

  task automatic smart(input logic [7:0] f, input logic ab);
    run(8'hb0, f, 8'h00, 4'h0);
    chk8({7'h0, st[0]}, {7'h0, ab}, "smart error flag");
  endtask

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    soft_rst = 1'b0;
    nv_smart_en = 1'b1;
    nv_valid = 1'b0;
    defect_pred = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].feat, rows[i].cnt, 4'h0);
      chk8({7'h0, st[0]}, {7'h0, rows[i].ab}, "command error flag");
      if (rows[i].ab) begin
        chk16(16'(host.n_words), 16'h0000, "aborted data phase");
        host.bus_rd(3'h0, st);
        chk8(st & 8'h04, 8'h04, "abort bit");
      end
    end
    run(8'hec, 8'h00, 8'h00, 4'h5);
    chk16(16'(host.n_words), 16'h0100, "identify length");
    chk8({3'h0, drive_sel, lba_head}, 8'h00, "drive only");
    chk16(host.buf_w[5], 16'h0200, "bytes per sector");
    chk16(host.buf_w[47], 16'h8001, "multiple limit");
    chk16(host.buf_w[75], 16'h001f, "queue depth");
    chk16(host.buf_w[63], 16'h0207, "dma modes");
    chk16(host.buf_w[57], 16'h3456, "capacity low");
    chk16(host.buf_w[58], 16'h0012, "capacity high");
    chk16(host.buf_w[19], 16'h3432, "serial tail");
    chk16(host.buf_w[27], 16'h464c, "model head");
    acc = host.buf_w[2] | host.buf_w[9];
    sum = 8'h00;
    for (int i = 0; i < 256; i++) begin
      sum = sum + host.buf_w[i][15:8] + host.buf_w[i][7:0];
      if (i >= 224 && i < 255) begin
        acc = acc | host.buf_w[i];
      end
    end
    chk16(acc, 16'h0000, "reserved words");
    chk8(host.buf_w[255][7:0], 8'ha5, "integrity mark");
    chk8(sum, 8'h00, "block checksum");
    run(8'h70, 8'h00, 8'h00, 4'h5);
    chk8({3'h0, drive_sel, lba_head}, 8'h05, "drive and head");
    run(8'hb0, 8'hd0, 8'h01, 4'h0);
    chk16(16'(host.n_words), 16'h0100, "smart data length");
    chk16(host.buf_w[0], 16'h0010, "smart revision");
    @(posedge sys_clk);
    defect_pred <= 1'b1;
    smart(8'hda, 1'b0);
    host.bus_rd(3'h4, st);
    chk8(st, 8'hf4, "defect low");
    host.bus_rd(3'h5, st);
    chk8(st, 8'h2c, "defect high");
    @(posedge sys_clk);
    defect_pred <= 1'b0;
    smart(8'hd9, 1'b0);
    chk8({7'h0, smart_active}, 8'h00, "monitoring stopped");
    chk8({7'h0, nv_smart_en}, 8'h00, "stored state");
    smart(8'hd0, 1'b1);
    chk16(16'(host.n_words), 16'h0000, "no data while off");
    smart(8'hda, 1'b1);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    nv_valid <= 1'b1;
    @(posedge sys_clk);
    nv_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk8({7'h0, smart_active}, 8'h00, "state after power cycle");
    smart(8'hd2, 1'b1);
    smart(8'hd8, 1'b0);
    chk8({7'h0, nv_smart_en}, 8'h01, "stored enable");
    acc = 16'(nv_writes);
    smart(8'hd8, 1'b0);
    chk8({7'h0, smart_active}, 8'h01, "enabled twice");
    chk16(16'(nv_writes), acc, "store on repeat enable");
    host.bus_wr(3'h0, 8'hec);
    repeat (6) @(posedge sys_clk);
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    @(negedge sys_clk);
    chk8({7'h0, data_valid}, 8'h00, "data dropped");
    host.bus_rd(3'h7, st);
    chk8(st & 8'h89, 8'h00, "idle after soft reset");
    complete_run();
  end
endmodule
